//--- inc/ram_board_pkg.sv
package ram_board_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W = 15;           // 32K-word system space
   localparam int DATA_W = 16;
   localparam int RAM_ADDR_W = 12;       // Low-order bits routed to the RAM
   localparam int BANK_COUNT = 2;
   localparam int BANK_WORDS_4K = 2048;  // Per bank on the 4K board
   localparam int BANK_WORDS_8K = 4096;  // Per bank on the 8K board
   localparam int REFRESH_ROWS = 64;     // One row refreshes 1/64 of memory
   localparam int ROW_W = 6;
   localparam int CNT_W = 8;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYCLE_NS = 960;
   localparam int RMW_NS = 1920;
   // Longest times round down to whole clocks
   localparam int CYCLE_CLKS = CYCLE_NS / CLK_PERIOD_NS;
   localparam int RMW_CLKS = RMW_NS / CLK_PERIOD_NS;
   localparam int READ_LAT = 2;          // Clocks from start to read word

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   localparam int GROUP_MSB = 14;        // Starting-address bit position 1
   localparam int GROUP_4K_LSB = 12;     // Position 3, used on 4K board only
   localparam int BANK_BIT_4K = 11;
   localparam int BANK_BIT_8K = 12;

   // ----------------------------------------
   // APB register map
   // ----------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] REFRESH_OFS = 12'h008;
   localparam logic [11:0] SUPPRESS_OFS = 12'h00c;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SIZE8K_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;   // Enabled, 4K board
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OP_LSB = 1;
   localparam int STAT_HIT_BIT = 3;
   localparam int STAT_SUPP_BIT = 4;
   localparam int STAT_DRIVE_BIT = 5;

   // ----------------------------------------
   // Memory bus operation codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_RMW = 2'h2,
      OP_REFRESH = 2'h3
   } mem_op_e;

endpackage

//--- design/board_select.sv
`timescale 1ns/1ps
module board_select (
   // Bus address
   input wire logic [ram_board_pkg::ADDR_W-1:0] addr,
   // Jumpers and size
   input wire logic start_addr_select_msb,
   input wire logic start_addr_select_mid,
   input wire logic start_addr_select_lsb,
   input wire logic size_8k,
   // Decode result
   output logic hit,
   output logic bank
);
   import ram_board_pkg::*;

   logic [2:0] group;

   // ----------------------------------------
   // Group compare and bank pick
   // ----------------------------------------
   // Inserted jumper means one, first jumper is the MSB
   assign group = {start_addr_select_msb, start_addr_select_mid, start_addr_select_lsb};

   // 8K board ignores the LSB jumper so it sits on an 8K boundary
   always_comb begin
      if (size_8k) begin
         hit = (addr[GROUP_MSB:GROUP_4K_LSB+1] == group[2:1]);
         bank = addr[BANK_BIT_8K];
      end else begin
         hit = (addr[GROUP_MSB:GROUP_4K_LSB] == group);
         bank = addr[BANK_BIT_4K];
      end
   end

endmodule

//--- design/dram_bank.sv
`timescale 1ns/1ps
module dram_bank #(
   parameter int WORDS = ram_board_pkg::BANK_WORDS_8K
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // Clock driver enable and access
   input wire logic clk_drv_en,
   input wire logic wr,
   input wire logic [ram_board_pkg::RAM_ADDR_W-1:0] addr,
   input wire logic [ram_board_pkg::DATA_W-1:0] wdata,
   output logic [ram_board_pkg::DATA_W-1:0] rdata,
   // Refresh
   input wire logic refresh,
   input wire logic [ram_board_pkg::ROW_W-1:0] row
);
   import ram_board_pkg::*;

   localparam int IDX_W = $clog2(WORDS);

   logic [DATA_W-1:0] mem [WORDS];
   logic [IDX_W-1:0] idx;
   logic [ROW_W-1:0] last_row;

   // Only the bits the bank depth needs are used
   assign idx = addr[IDX_W-1:0];

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Array holds no reset; only the clock-driven bank is touched
   always_ff @(posedge mclk) begin
      if (ce && clk_drv_en && wr) begin
         mem[idx] <= wdata;
      end
   end

   // Read word capture
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 16'h0000;
      end else if (ce && clk_drv_en && !wr) begin
         rdata <= mem[idx];
      end
   end

   // Row refresh leaves data paths alone; stores the row last refreshed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         last_row <= 6'h00;
      end else if (ce && refresh) begin
         last_row <= row;
      end
   end

endmodule

//--- design/dram_board.sv
`timescale 1ns/1ps
// Operation
// - Storage is two separate DRAM banks of 2,048 or 4,096 16-bit words each.
// - At cycle start the bus address is compared with the jumper range; only a hit or a refresh takes part.
// - A hit enables the picked bank's clock driver and sends twelve low address bits to the RAM.
// - A read fetches the word and drives it onto the bus only while the disable line is low.
// - A write stores the 16-bit bus word through the write data path at the address.
// - A read-modify-write first drives the word out unless the ROM disable line is asserted.
// - A read-modify-write keeps the location open until new data arrives, then writes it there; the code ends it unwritten after RMW_CLKS-1 clocks if none arrives.
// - A refresh refreshes 1/64 of the memory at once with no data moving on either path.
// - Three jumpers give starting-address bits 1 to 3, inserted is one, first jumper is MSB.
// - The 8K board ignores the least significant jumper and decodes an 8K-aligned group.
// - The whole system addresses at most 32K words and groups are placed within it.
// - Shared ROM and RAM addresses are settled in favour of the ROM by the shared line.
// - Read, write and refresh cycles complete within 960 ns.
// - A read-modify-write cycle completes within 1920 ns.
module dram_board (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // Memory bus control
   input wire logic mem_start,
   input wire ram_board_pkg::mem_op_e mem_op,
   input wire logic [ram_board_pkg::ADDR_W-1:0] mem_addr,
   input wire logic mem_wdata_valid,
   output logic mem_done,
   // Memory bus data, two-way
   input wire logic [ram_board_pkg::DATA_W-1:0] mem_data_in,
   output logic [ram_board_pkg::DATA_W-1:0] mem_data_out,
   output logic mem_data_oe_b,
   // ROM priority
   input wire logic ram_disable_priority_line,
   // Starting-address jumpers
   input wire logic start_addr_select_msb,
   input wire logic start_addr_select_mid,
   input wire logic start_addr_select_lsb,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import ram_board_pkg::*;

   typedef enum logic [1:0] {
      IDLE,
      ACCESS,
      RMW_WAIT
   } cycle_state_e;

   cycle_state_e state;
   cycle_state_e next_state;

   logic [1:0] ctrl;
   logic [CNT_W-1:0] cnt;
   mem_op_e op;
   logic [RAM_ADDR_W-1:0] ram_addr;
   logic [DATA_W-1:0] wdata;
   logic bank_sel;
   logic sel_hit;
   logic sel_bank;
   logic take;
   logic hit;
   logic last_hit;
   logic drive;
   logic suppressed;
   logic busy;
   logic bank_cmd;
   logic bank_wr;
   logic refresh_cmd;
   logic [ROW_W-1:0] row;
   logic [15:0] suppress_cnt;
   logic [DATA_W-1:0] bank_rdata [BANK_COUNT];
   logic apb_wr;
   logic apb_rd;
   logic mapped;
   logic done_cond;

   // ----------------------------------------
   // Board and bank selection
   // ----------------------------------------
   board_select u_select (
      .addr(mem_addr),
      .start_addr_select_msb(start_addr_select_msb),
      .start_addr_select_mid(start_addr_select_mid),
      .start_addr_select_lsb(start_addr_select_lsb),
      .size_8k(ctrl[CTRL_SIZE8K_BIT]),
      .hit(sel_hit),
      .bank(sel_bank)
   );

   // Cycle taken when idle; refresh involves every board
   assign take = ce && mem_start && (state == IDLE);
   assign hit = sel_hit && ctrl[CTRL_ENABLE_BIT];

   // ----------------------------------------
   // DRAM banks
   // ----------------------------------------
   // Each bank has its own clock driver enable
   for (genvar b = 0; b < BANK_COUNT; b++) begin : g_bank
      dram_bank #(
         .WORDS(BANK_WORDS_8K)
      ) u_bank (
         .mclk(mclk),
         .rst_b(rst_b),
         .ce(ce),
         .clk_drv_en(bank_cmd && (bank_sel == 1'(b))),
         .wr(bank_wr),
         .addr(ram_addr),
         .wdata(wdata),
         .rdata(bank_rdata[b]),
         .refresh(refresh_cmd),
         .row(row)
      );
   end

   // ----------------------------------------
   // Cycle sequencer
   // ----------------------------------------
   // Read and write end at the cycle limit; RMW ends on new data, or at cnt RMW_CLKS-1 if none arrives
   assign done_cond = (state == ACCESS) && (cnt == CNT_W'(CYCLE_CLKS - 1));

   always_comb begin
      next_state = state;
      unique case (state)
         IDLE: begin
            if (take && (hit || mem_op == OP_REFRESH)) begin
               next_state = ACCESS;
            end
         end
         ACCESS: begin
            if (op == OP_RMW && cnt == CNT_W'(READ_LAT)) begin
               next_state = RMW_WAIT;
            end else if (done_cond) begin
               next_state = IDLE;
            end
         end
         RMW_WAIT: begin
            if (mem_wdata_valid || cnt == CNT_W'(RMW_CLKS - 1)) begin
               next_state = IDLE;
            end
         end
         default: next_state = IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Cycle counter from the start edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 8'h00;
      end else if (ce) begin
         if (state == IDLE) begin
            cnt <= 8'h01;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   // Latch operation, low address bits and bank at the start
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         op <= OP_READ;
         ram_addr <= 12'h000;
         bank_sel <= 1'b0;
         last_hit <= 1'b0;
      end else if (take) begin
         op <= mem_op;
         ram_addr <= mem_addr[RAM_ADDR_W-1:0];
         bank_sel <= sel_bank;
         last_hit <= hit;
      end
   end

   // Bank commands: one clock for read or write, held off on a miss
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bank_cmd <= 1'b0;
         bank_wr <= 1'b0;
         wdata <= 16'h0000;
      end else if (ce) begin
         bank_cmd <= 1'b0;
         bank_wr <= 1'b0;
         if (take && hit && mem_op != OP_REFRESH) begin
            bank_cmd <= 1'b1;
            bank_wr <= (mem_op == OP_WRITE);
            wdata <= mem_data_in;
         end else if (state == RMW_WAIT && mem_wdata_valid) begin
            bank_cmd <= 1'b1;
            bank_wr <= 1'b1;
            wdata <= mem_data_in;
         end
      end
   end

   // Refresh row pointer steps through 64 rows
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         refresh_cmd <= 1'b0;
         row <= 6'h00;
      end else if (ce) begin
         refresh_cmd <= take && (mem_op == OP_REFRESH);
         if (refresh_cmd) begin
            row <= row + 6'h01;
         end
      end
   end

   // ----------------------------------------
   // Bus data drive
   // ----------------------------------------
   // Read word captured into the output flops, then driven
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mem_data_out <= 16'h0000;
         drive <= 1'b0;
      end else if (ce) begin
         if (state == ACCESS && cnt == CNT_W'(READ_LAT)
             && (op == OP_READ || op == OP_RMW)) begin
            mem_data_out <= bank_rdata[bank_sel];
            drive <= 1'b1;
         end else if (mem_done || (state == RMW_WAIT && mem_wdata_valid)) begin
            drive <= 1'b0;
         end
      end
   end

   // ROM priority line gates the driver at once
   assign mem_data_oe_b = !(drive && !ram_disable_priority_line);

   // Done pulse when a participating cycle ends
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mem_done <= 1'b0;
      end else if (ce) begin
         mem_done <= (state != IDLE) && (next_state == IDLE);
      end
   end

   // Count reads whose word was withheld for a ROM
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         suppressed <= 1'b0;
         suppress_cnt <= 16'h0000;
      end else if (ce) begin
         if (drive && ram_disable_priority_line && !suppressed) begin
            suppressed <= 1'b1;
            suppress_cnt <= suppress_cnt + 16'h0001;
         end else if (take) begin
            suppressed <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // APB registers
   // ----------------------------------------
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !pwrite;
   assign busy = (state != IDLE);
   assign pready = 1'b1;
   assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS)
                   || (paddr == REFRESH_OFS) || (paddr == SUPPRESS_OFS);
   assign pslverr = psel && penable && !mapped;

   // Control: board enable and 8K size
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= CTRL_RESET;
      end else if (ce && apb_wr && paddr == CTRL_OFS) begin
         ctrl <= pwdata[1:0];
      end
   end

   // Read data registered in the setup cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (ce && apb_rd && !penable) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            CTRL_OFS: prdata[1:0] <= ctrl;
            STATUS_OFS: begin
               prdata[STAT_BUSY_BIT] <= busy;
               prdata[STAT_OP_LSB+:2] <= op;
               prdata[STAT_HIT_BIT] <= last_hit;
               prdata[STAT_SUPP_BIT] <= suppressed;
               prdata[STAT_DRIVE_BIT] <= drive;
            end
            REFRESH_OFS: prdata[ROW_W-1:0] <= row;
            SUPPRESS_OFS: prdata[15:0] <= suppress_cnt;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

//--- dv/dram_board_assertions.sv
`timescale 1ns/1ps
module dram_board_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // Memory bus
   input wire logic mem_start,
   input wire ram_board_pkg::mem_op_e mem_op,
   input wire logic [ram_board_pkg::ADDR_W-1:0] mem_addr,
   input wire logic mem_wdata_valid,
   input wire logic mem_done,
   input wire logic mem_data_oe_b,
   input wire logic ram_disable_priority_line,
   // Jumpers
   input wire logic start_addr_select_msb,
   input wire logic start_addr_select_mid,
   input wire logic start_addr_select_lsb,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata
);
   import ram_board_pkg::*;
   logic busy, is_rmw, is_ref, size8k, en, hit, take;
   logic [2:0] jmp;
   // ----------------------------------------
   // Decode and cycle tracking
   // ----------------------------------------
   assign jmp = {start_addr_select_msb, start_addr_select_mid, start_addr_select_lsb};
   assign hit = size8k ? mem_addr[14:13] == jmp[2:1] : mem_addr[14:12] == jmp;
   assign take = ce && mem_start && !busy && (mem_op == OP_REFRESH || (hit && en));
   // Busy from a taken start until its done pulse
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'h0;
         is_rmw <= 1'h0;
         is_ref <= 1'h0;
      end else if (take) begin
         busy <= 1'h1;
         is_rmw <= mem_op == OP_RMW;
         is_ref <= mem_op == OP_REFRESH;
      end else if (mem_done) begin
         busy <= 1'h0;
      end
   end
   // Mirror of the size and enable control bits
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         {size8k, en} <= CTRL_RESET;
      end else if (ce && psel && penable && pwrite && paddr == CTRL_OFS) begin
         {size8k, en} <= pwdata[1:0];
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_take_short;
      take && mem_op != OP_RMW;
   endsequence
   sequence s_rmw_end;
      busy && is_rmw && mem_wdata_valid;
   endsequence
   AST_CYCLE_TIME: assert property (s_take_short |-> ##96 mem_done)
      else $error("cycle end missed");
   AST_NOT_EARLY: assert property (s_take_short |=> !mem_done [*8])
      else $error("done too early");
   AST_MISS_QUIET: assert property (ce && mem_start && !busy && !take
      |=> (mem_data_oe_b && !mem_done) [*8])
      else $error("miss took part");
   AST_PRIORITY: assert property (ram_disable_priority_line |-> mem_data_oe_b)
      else $error("drive during priority");
   AST_READ_DRIVE: assert property (take && mem_op == OP_READ
      |-> ##4 mem_data_oe_b == ram_disable_priority_line)
      else $error("read drive wrong");
   AST_RMW_DRIVE: assert property (take && mem_op == OP_RMW
      ##4 (!mem_wdata_valid && !ram_disable_priority_line) |-> !mem_data_oe_b)
      else $error("rmw word not driven");
   AST_RMW_WRITE: assert property (s_rmw_end |=> mem_done && mem_data_oe_b)
      else $error("rmw end wrong");
   AST_RMW_BOUND: assert property (take && mem_op == OP_RMW |-> ##[1:192] mem_done)
      else $error("rmw too long");
   AST_REFRESH_QUIET: assert property (busy && is_ref |-> mem_data_oe_b)
      else $error("refresh drove bus");
endmodule

bind dram_board dram_board_checker dram_board_checker_i (
   .mclk, .rst_b, .ce, .mem_start, .mem_op, .mem_addr, .mem_wdata_valid, .mem_done,
   .mem_data_oe_b, .ram_disable_priority_line, .start_addr_select_msb,
   .start_addr_select_mid, .start_addr_select_lsb, .psel, .penable, .pwrite, .paddr, .pwdata
);

//--- dv/rom_board_model.sv
`timescale 1ns/1ps
module rom_board_model (
   // Clock and bus request
   input wire logic mclk,
   input wire logic mem_start,
   input wire ram_board_pkg::mem_op_e mem_op,
   input wire logic [14:0] mem_addr,
   input wire logic mem_done,
   // RAM board data lines
   input wire logic [15:0] ram_data,
   input wire logic ram_oe_b,
   // ROM setup
   input wire logic rom_en,
   input wire logic [14:0] rom_addr,
   input wire logic [15:0] rom_word,
   // Priority line and resolved bus
   output logic ram_disable_priority_line,
   output logic [15:0] bus
);
   import ram_board_pkg::*;
   logic active = 1'h0;
   logic [15:0] last = 16'h0000;
   // Claim a read or rmw at the ROM address until the cycle ends
   always_ff @(posedge mclk) begin
      if (mem_start && rom_en && mem_addr == rom_addr && mem_op inside {OP_READ, OP_RMW}) begin
         active <= 1'h1;
      end else if (mem_done) begin
         active <= 1'h0;
      end
   end
   // Line asserted whenever the ROM word is on the bus
   assign ram_disable_priority_line = active;
   // Undriven lines toggle so a stale word never passes
   assign bus = active ? rom_word : (!ram_oe_b ? ram_data : ~last);
   always_ff @(posedge mclk) begin
      last <= bus;
   end
endmodule

//--- dv/dram_board_tb.sv
`timescale 1ns/1ps
module dram_board_tb;
   import ram_board_pkg::*;
   logic mclk = 1'h0;
   logic rst_b = 1'h0;
   logic ce = 1'h1;
   logic mem_start = 1'h0;
   mem_op_e mem_op = OP_READ;
   logic [14:0] mem_addr = 15'h0000;
   logic mem_wdata_valid = 1'h0;
   logic [15:0] mem_data_in = 16'h0000;
   logic [2:0] jmp = 3'h6;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic rom_en = 1'h0;
   logic [14:0] rom_addr = 15'h0000;
   logic [15:0] rom_word = 16'h0000;
   logic mem_done, mem_data_oe_b, pready, pslverr, ram_disable_priority_line, e;
   logic [15:0] mem_data_out, bus;
   logic [31:0] prdata, q;
   localparam logic [15:0] nil = 16'h0000;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;

   dram_board dram_board_i (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .mem_start(mem_start), .mem_op(mem_op),
      .mem_addr(mem_addr), .mem_wdata_valid(mem_wdata_valid), .mem_done(mem_done),
      .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
      .mem_data_oe_b(mem_data_oe_b), .ram_disable_priority_line(ram_disable_priority_line),
      .start_addr_select_msb(jmp[2]), .start_addr_select_mid(jmp[1]),
      .start_addr_select_lsb(jmp[0]), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );
   rom_board_model rom_board_model_i (
      .mclk(mclk), .mem_start(mem_start), .mem_op(mem_op), .mem_addr(mem_addr),
      .mem_done(mem_done), .ram_data(mem_data_out), .ram_oe_b(mem_data_oe_b),
      .rom_en(rom_en), .rom_addr(rom_addr), .rom_word(rom_word),
      .ram_disable_priority_line(ram_disable_priority_line), .bus(bus)
   );

   // Clock and hang guard
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do @(posedge mclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // One memory cycle; bus sampled once the word must stand
   task automatic op_chk(input mem_op_e op, input logic [14:0] a, input logic [15:0] d,
         input logic [15:0] d2, input logic [15:0] eg, input logic ed, input logic edn);
      int n;
      logic [15:0] got;
      logic drove, done;
      n = 0;
      done = 1'h0;
      drove = 1'h0;
      got = nil;
      @(posedge mclk);
      mem_start <= 1'h1;
      mem_op <= op;
      mem_addr <= a;
      mem_data_in <= d;
      @(posedge mclk);
      mem_start <= 1'h0;
      while (!done && n < 250) begin
         @(negedge mclk);
         n++;
         done = mem_done === 1'h1;
         if (n == 6) begin
            got = bus;
            drove = !mem_data_oe_b;
         end
         if (n == 6 && op == OP_RMW) begin
            @(posedge mclk);
            mem_wdata_valid <= 1'h1;
            mem_data_in <= d2;
            @(posedge mclk);
            mem_wdata_valid <= 1'h0;
         end
      end
      check("done", 32'(done), 32'(edn));
      check("in time", 32'(n <= (op == OP_RMW ? RMW_CLKS : CYCLE_CLKS)), 32'(edn));
      check("drive", 32'(drove), 32'(ed));
      if (ed || rom_en) begin
         check("word", 32'(got), 32'(eg));
      end
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'h1;
      // Register bus: reset value and unmapped place
      apb(1'h0, CTRL_OFS, 32'h0000_0000);
      check("ctrl", q, 32'(CTRL_RESET));
      apb(1'h0, 12'h010, 32'h0000_0000);
      check("unmapped err", 32'(e), 32'h0000_0001);
      check("unmapped data", q, 32'h0000_0000);
      // Same low bits in both banks
      op_chk(OP_WRITE, 15'h6005, 16'h1234, nil, nil, 1'h0, 1'h1);
      op_chk(OP_WRITE, 15'h6805, 16'habcd, nil, nil, 1'h0, 1'h1);
      op_chk(OP_READ, 15'h6005, nil, nil, 16'h1234, 1'h1, 1'h1);
      op_chk(OP_READ, 15'h6805, nil, nil, 16'habcd, 1'h1, 1'h1);
      // Reversed jumper group misses
      op_chk(OP_WRITE, 15'h3005, 16'h5555, nil, nil, 1'h0, 1'h0);
      op_chk(OP_READ, 15'h3005, nil, nil, nil, 1'h0, 1'h0);
      op_chk(OP_READ, 15'h6005, nil, nil, 16'h1234, 1'h1, 1'h1);
      // Read-modify-write then read back
      op_chk(OP_RMW, 15'h6005, nil, 16'h7777, 16'h1234, 1'h1, 1'h1);
      op_chk(OP_READ, 15'h6005, nil, nil, 16'h7777, 1'h1, 1'h1);
      // Refresh on any address moves no data
      op_chk(OP_REFRESH, 15'h0000, nil, nil, nil, 1'h0, 1'h1);
      // One refresh steps the row pointer by one
      apb(1'h0, REFRESH_OFS, 32'h0000_0000);
      check("refresh row", q, 32'h0000_0001);
      // ROM overlay wins the bus
      @(posedge mclk);
      rom_en <= 1'h1;
      rom_addr <= 15'h6805;
      rom_word <= 16'hc3c3;
      op_chk(OP_READ, 15'h6805, nil, nil, 16'hc3c3, 1'h0, 1'h1);
      op_chk(OP_RMW, 15'h6805, nil, 16'h2468, 16'hc3c3, 1'h0, 1'h1);
      @(posedge mclk);
      rom_en <= 1'h0;
      op_chk(OP_READ, 15'h6805, nil, nil, 16'h2468, 1'h1, 1'h1);
      // Both ROM cycles counted as withheld
      apb(1'h0, SUPPRESS_OFS, 32'h0000_0000);
      check("suppressed", q, 32'h0000_0002);
      // 8K board ignores the last jumper
      apb(1'h1, CTRL_OFS, 32'h0000_0003);
      apb(1'h0, CTRL_OFS, 32'h0000_0000);
      check("ctrl 8k", q, 32'h0000_0003);
      op_chk(OP_WRITE, 15'h7005, 16'h0f0f, nil, nil, 1'h0, 1'h1);
      op_chk(OP_READ, 15'h7005, nil, nil, 16'h0f0f, 1'h1, 1'h1);
      op_chk(OP_READ, 15'h6005, nil, nil, 16'h7777, 1'h1, 1'h1);
      op_chk(OP_READ, 15'h5005, nil, nil, nil, 1'h0, 1'h0);
      finish_test();
   end
endmodule
